// File: rtl/strap_config_enable_power_good.sv
// strap decode, enable sequencing and power-good drive of the converter
`include "converter_params.svh"
// What this block does
// - bias the output-voltage strap, digitize it and latch the setpoint before regulating
// - map strap codes to setpoints 3.3V down to 1.35V; two lowest and two highest codes reserved
// - enable high starts a soft-start ramp toward the setpoint
// - enable low ramps the output down in steps before stopping
// - pre-charged output starts the ramp from the measured voltage
// - power-good stays low while output is below 90% of setpoint
// - power-good only while in regulation and without major fault
// - fault drops power-good; it returns once the output recovers
// - address 0x01 to 0x40 drives power-good push-pull
// - address 0x41 to 0x7F drives power-good open-drain
// - compensator chosen from a single strap measurement
// - five base compensators, six capacitance multipliers each
module strap_config_enable_power_good #(
    parameter int MV_W          = 12,
    parameter int RAMP_STEP_MV  = 1,
    parameter int PREBIAS_MIN_MV = 50
) (
    input  wire logic                      core_clk,
    input  wire logic                      reset,
    input  wire logic                      enable_pin,
    input  wire logic [6:0]                bus_addr_strap,
    input  wire logic                      vout_adc_valid,
    input  wire logic [`STRAP_CODE_W-1:0]  vout_adc_code,
    input  wire logic                      comp_adc_valid,
    input  wire logic [`STRAP_CODE_W-1:0]  comp_adc_code,
    input  wire logic [MV_W-1:0]           vout_meas_mv,
    input  wire logic                      major_fault,
    output logic                           vout_select_strap_bias,
    output logic                           compensator_select_strap_bias,
    output logic                           config_done,
    output logic                           vout_code_reserved,
    output logic [MV_W-1:0]                setpoint_mv,
    output logic [MV_W-1:0]                ref_mv,
    output logic                           converter_run,
    output logic                           prebias_start,
    output converter_pkg::comp_sel_t       compensator,
    output logic                           power_good_out,
    output logic                           power_good_oe
);
    // ************************************************************
    // parameters and checks
    // ************************************************************
    localparam int SETTLE_CYC = (`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int STEP_CYC   = (`RAMP_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam logic [11:0] vout_tab [0:27] = `VOUT_TABLE;

    if (MV_W != 12 || RAMP_STEP_MV < 1 || PREBIAS_MIN_MV < 1) begin : g_chk
        $error("strap_config_enable_power_good: unsupported parameter values");
    end

    // ************************************************************
    // strap sampling
    // ************************************************************
    logic                      vout_done;
    logic                      comp_done;
    logic [`STRAP_CODE_W-1:0]  vout_code;
    logic [`STRAP_CODE_W-1:0]  comp_code;

    strap_sampler #(.SETTLE_CYC(SETTLE_CYC), .CODE_W(`STRAP_CODE_W)) u_vout_strap (
        .core_clk  (core_clk),
        .reset     (reset),
        .adc_valid (vout_adc_valid),
        .adc_code  (vout_adc_code),
        .bias_en   (vout_select_strap_bias),
        .code_q    (vout_code),
        .done_q    (vout_done)
    );

    strap_sampler #(.SETTLE_CYC(SETTLE_CYC), .CODE_W(`STRAP_CODE_W)) u_comp_strap (
        .core_clk  (core_clk),
        .reset     (reset),
        .adc_valid (comp_adc_valid),
        .adc_code  (comp_adc_code),
        .bias_en   (compensator_select_strap_bias),
        .code_q    (comp_code),
        .done_q    (comp_done)
    );

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic       en_s1_q;
    logic       en_s2_q;
    logic [6:0] addr_s1_q;
    logic [6:0] addr_s2_q;

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            en_s1_q   <= 1'b0;
            en_s2_q   <= 1'b0;
            addr_s1_q <= 7'h00;
            addr_s2_q <= 7'h00;
        end
        else
        begin
            en_s1_q   <= enable_pin;
            en_s2_q   <= en_s1_q;
            addr_s1_q <= bus_addr_strap;
            addr_s2_q <= addr_s1_q;
        end
    end

    // ************************************************************
    // decode and sequencing
    // ************************************************************
    converter_pkg::conv_state_t st_q, st_d;
    logic [MV_W-1:0]            ref_d;
    logic [MV_W-1:0]            sp_d;
    logic                       rsv_d;
    logic                       pb_d;
    logic                       cfg_d;
    logic                       pp_mode_q, pp_mode_d;
    logic                       mode_ok_q, mode_ok_d;
    logic                       pg_q, pg_d;
    logic                       above_thr;
    converter_pkg::comp_sel_t   comp_d;
    logic [12:0]                tick_cnt_q, tick_cnt_d;
    logic                       tick;
    logic [MV_W:0]              ref_up;
    logic                       meas_prebias;

    assign tick         = (tick_cnt_q == 13'(STEP_CYC - 1));
    assign ref_up       = {1'b0, ref_mv} + (MV_W+1)'(RAMP_STEP_MV);
    assign meas_prebias = (vout_meas_mv > MV_W'(PREBIAS_MIN_MV));
    assign above_thr    = (16'(vout_meas_mv) * 16'(`PG_RATIO_DEN))
                          >= (16'(setpoint_mv) * 16'(`PG_RATIO_NUM));

    always_comb
    begin
        st_d       = st_q;
        ref_d      = ref_mv;
        sp_d       = setpoint_mv;
        rsv_d      = vout_code_reserved;
        pb_d       = prebias_start;
        cfg_d      = config_done;
        comp_d     = compensator;
        pp_mode_d  = pp_mode_q;
        mode_ok_d  = mode_ok_q;
        tick_cnt_d = tick ? 13'h0000 : tick_cnt_q + 13'h0001;
        case (st_q)
            converter_pkg::ST_STRAP:
            begin
                if (vout_done && comp_done)
                begin
                    cfg_d = 1'b1;
                    if (vout_code < `VOUT_FIRST_CODE || vout_code > `VOUT_LAST_CODE)
                    begin
                        rsv_d = 1'b1;
                    end
                    else
                    begin
                        sp_d = vout_tab[vout_code - `VOUT_FIRST_CODE];
                    end
                    if (comp_code <= `COMP_LAST_CODE)
                    begin
                        comp_d.base = 3'(comp_code / `COMP_GROUP_SIZE);
                        comp_d.mult = 3'(comp_code % `COMP_GROUP_SIZE);
                    end
                    pp_mode_d = (addr_s2_q >= `ADDR_PP_LOW)
                                && (addr_s2_q <= `ADDR_PP_HIGH);
                    mode_ok_d = 1'b1;
                    st_d      = converter_pkg::ST_OFF;
                end
            end
            converter_pkg::ST_OFF:
            begin
                ref_d = `MV_RESET;
                if (en_s2_q && !vout_code_reserved && !major_fault)
                begin
                    st_d = converter_pkg::ST_RAMP;
                    pb_d = meas_prebias;
                    if (meas_prebias)
                    begin
                        ref_d = (vout_meas_mv < setpoint_mv) ? vout_meas_mv : setpoint_mv;
                    end
                end
            end
            converter_pkg::ST_RAMP:
            begin
                if (major_fault)
                begin
                    st_d = converter_pkg::ST_FAULT;
                end
                else if (!en_s2_q)
                begin
                    st_d = converter_pkg::ST_SHUT;
                end
                else if (tick)
                begin
                    if (ref_up >= {1'b0, setpoint_mv})
                    begin
                        ref_d = setpoint_mv;
                        st_d  = converter_pkg::ST_ON;
                    end
                    else
                    begin
                        ref_d = ref_up[MV_W-1:0];
                    end
                end
            end
            converter_pkg::ST_ON:
            begin
                pb_d = 1'b0;
                if (major_fault)
                begin
                    st_d = converter_pkg::ST_FAULT;
                end
                else if (!en_s2_q)
                begin
                    st_d = converter_pkg::ST_SHUT;
                end
            end
            converter_pkg::ST_SHUT:
            begin
                if (major_fault)
                begin
                    st_d = converter_pkg::ST_FAULT;
                end
                else if (tick)
                begin
                    if (ref_mv <= MV_W'(RAMP_STEP_MV))
                    begin
                        ref_d = `MV_RESET;
                        st_d  = converter_pkg::ST_OFF;
                    end
                    else
                    begin
                        ref_d = ref_mv - MV_W'(RAMP_STEP_MV);
                    end
                end
            end
            default:
            begin
                ref_d = `MV_RESET;
                pb_d  = 1'b0;
                if (!major_fault)
                begin
                    st_d = converter_pkg::ST_OFF;
                end
            end
        endcase
        pg_d = (st_q == converter_pkg::ST_ON) && !major_fault && above_thr;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            st_q               <= converter_pkg::ST_STRAP;
            ref_mv             <= `MV_RESET;
            setpoint_mv        <= `MV_RESET;
            vout_code_reserved <= 1'b0;
            prebias_start      <= 1'b0;
            config_done        <= 1'b0;
            compensator        <= '0;
            pp_mode_q          <= 1'b0;
            mode_ok_q          <= 1'b0;
            tick_cnt_q         <= 13'h0000;
            pg_q               <= 1'b0;
            converter_run      <= 1'b0;
            power_good_out     <= 1'b0;
            power_good_oe      <= 1'b0;
        end
        else
        begin
            st_q               <= st_d;
            ref_mv             <= ref_d;
            setpoint_mv        <= sp_d;
            vout_code_reserved <= rsv_d;
            prebias_start      <= pb_d;
            config_done        <= cfg_d;
            compensator        <= comp_d;
            pp_mode_q          <= pp_mode_d;
            mode_ok_q          <= mode_ok_d;
            tick_cnt_q         <= tick_cnt_d;
            pg_q               <= pg_d;
            converter_run      <= (st_d == converter_pkg::ST_RAMP)
                                  || (st_d == converter_pkg::ST_ON)
                                  || (st_d == converter_pkg::ST_SHUT);
            power_good_out     <= mode_ok_q && pp_mode_q && pg_q;
            power_good_oe      <= mode_ok_q && (pp_mode_q || !pg_q);
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_strap_first: assert property (converter_run |-> config_done)
        else $error("converter ran before the straps were latched");
    chk_reserved_code: assert property (vout_code_reserved |-> !converter_run)
        else $error("reserved setpoint code allowed conversion");
    chk_enable_ramp: assert property ((st_q == converter_pkg::ST_OFF) && en_s2_q
        && !vout_code_reserved && !major_fault |=> converter_run)
        else $error("enable did not start the ramp");
    chk_shut_stepdown: assert property ((st_q == converter_pkg::ST_SHUT) && !major_fault
        |=> ref_mv <= $past(ref_mv))
        else $error("reference rose during shutdown");
    chk_prebias_ref: assert property ((st_q == converter_pkg::ST_OFF) && st_d
        == converter_pkg::ST_RAMP && meas_prebias && vout_meas_mv < setpoint_mv
        |=> prebias_start && ref_mv == $past(vout_meas_mv))
        else $error("pre-bias start did not begin at the measured voltage");
    chk_pg_threshold: assert property (pg_q |-> $past(16'(vout_meas_mv) * 16'(`PG_RATIO_DEN)
        >= 16'(setpoint_mv) * 16'(`PG_RATIO_NUM)))
        else $error("power-good high below threshold");

    // internal flag drops first, the pin one cycle later
    sequence pg_drop_s;
        !pg_q ##1 !power_good_out;
    endsequence

    chk_pg_fault: assert property (major_fault |=> pg_drop_s)
        else $error("power-good stayed up during a fault");
    chk_pg_pushpull: assert property (mode_ok_q && pp_mode_q |=> power_good_oe)
        else $error("push-pull power-good not driven");
    chk_pg_opendrain: assert property (mode_ok_q && !pp_mode_q |=> !power_good_out
        && (power_good_oe == !$past(pg_q)))
        else $error("open-drain power-good drove high");
    chk_comp_range: assert property (config_done |-> compensator.base <= 3'h4
        && compensator.mult <= 3'h5)
        else $error("compensator selection out of range");
    chk_mode_held: assert property (mode_ok_q |=> $stable(pp_mode_q) && mode_ok_q)
        else $error("power-good mode changed after latching");
endmodule

// File: rtl/converter_params.svh
// timing, field and reset constants for the converter control block
`ifndef CONVERTER_PARAMS_SVH
`define CONVERTER_PARAMS_SVH
`define CLK_PERIOD_NS     10
`define STRAP_SETTLE_NS   1000
`define RAMP_STEP_NS      1000
`define STRAP_CODE_W      5
`define VOUT_FIRST_CODE   5'h02
`define VOUT_LAST_CODE    5'h1D
`define COMP_LAST_CODE    5'h1D
`define COMP_GROUP_SIZE   5'h06
`define PG_RATIO_NUM      4'h9
`define PG_RATIO_DEN      4'hA
`define ADDR_PP_LOW       7'h01
`define ADDR_PP_HIGH      7'h40
`define ADDR_OD_LOW       7'h41
`define ADDR_OD_HIGH      7'h7F
`define MV_RESET          12'h000
`define VOUT_TABLE '{12'hCE4, 12'hC80, 12'hC1C, 12'hBB8, 12'hB54, 12'hAF0, 12'hA8C, \
    12'hA28, 12'h9C4, 12'h960, 12'h8FC, 12'h898, 12'h834, 12'h7D0, 12'h76C, 12'h708, \
    12'h6D6, 12'h6A4, 12'h672, 12'h640, 12'h60E, 12'h5DC, 12'h5C3, 12'h5AA, 12'h591, \
    12'h578, 12'h55F, 12'h546}
`endif

// File: rtl/converter_pkg.sv
// types shared by the converter control block
package converter_pkg;
    typedef enum logic [2:0] {
        ST_STRAP = 3'h0,
        ST_OFF   = 3'h1,
        ST_RAMP  = 3'h3,
        ST_ON    = 3'h2,
        ST_SHUT  = 3'h6,
        ST_FAULT = 3'h4
    } conv_state_t;

    typedef enum logic [1:0] {
        SMP_SETTLE = 2'h0,
        SMP_CONV   = 2'h1,
        SMP_DONE   = 2'h3
    } sample_state_t;

    typedef struct packed {
        logic [2:0] base;
        logic [2:0] mult;
    } comp_sel_t;
endpackage

// File: rtl/strap_sampler.sv
// biases one strap resistor, waits for settling, latches the digitized code
`include "converter_params.svh"
module strap_sampler #(
    parameter int SETTLE_CYC = 1,
    parameter int CODE_W     = 5
) (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              adc_valid,
    input  wire logic [CODE_W-1:0] adc_code,
    output logic                   bias_en,
    output logic [CODE_W-1:0]      code_q,
    output logic                   done_q
);
    if (SETTLE_CYC < 1 || SETTLE_CYC > 4096) begin : g_chk
        $error("strap_sampler: SETTLE_CYC out of range");
    end

    converter_pkg::sample_state_t st_q, st_d;
    logic [12:0]                  cnt_q, cnt_d;
    logic [CODE_W-1:0]            code_d;

    always_comb
    begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        code_d = code_q;
        case (st_q)
            converter_pkg::SMP_SETTLE:
            begin
                cnt_d = cnt_q + 13'h0001;
                if (cnt_q == 13'(SETTLE_CYC - 1))
                begin
                    st_d = converter_pkg::SMP_CONV;
                end
            end
            converter_pkg::SMP_CONV:
            begin
                if (adc_valid)
                begin
                    code_d = adc_code;
                    st_d   = converter_pkg::SMP_DONE;
                end
            end
            default:
            begin
                st_d = converter_pkg::SMP_DONE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            st_q    <= converter_pkg::SMP_SETTLE;
            cnt_q   <= 13'h0000;
            code_q  <= '0;
            bias_en <= 1'b1;
            done_q  <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            code_q  <= code_d;
            bias_en <= (st_d != converter_pkg::SMP_DONE);
            done_q  <= (st_d == converter_pkg::SMP_DONE);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_bias_until_latch: assert property (!done_q |-> bias_en)
        else $error("strap bias dropped before the code was latched");
endmodule

// File: test/sequencer_plant_model.sv
// far-side model: output plant, sequencer wire and power-good pull-up
module sequencer_plant_model (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        converter_run,
    input  wire logic [11:0] ref_mv,
    input  wire logic [11:0] precharge_mv,
    input  wire logic [11:0] droop_mv,
    input  wire logic        power_good_out,
    input  wire logic        power_good_oe,
    output logic [11:0]      vout_meas_mv,
    output logic             pg_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // output follows the reference while running, else sits at its precharge
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            vout_meas_mv <= precharge_mv;
        else if (converter_run)
            vout_meas_mv <= ref_mv - droop_mv;
        else
            vout_meas_mv <= precharge_mv;
    end

    // external pull-up fitted: released pin reads high
    assign pg_pin = power_good_oe ? power_good_out : 1'b1;
endmodule

// File: test/strap_config_enable_power_good_tb.sv
// self-checking bench for strap decode, enable sequencing and power-good
`define CHECK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); \
        end \
    end
module strap_config_enable_power_good_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [4:0]  vcode;
        logic [4:0]  ccode;
        logic [6:0]  addr;
        logic [11:0] sp;
        logic        rsv;
        logic [2:0]  base;
        logic [2:0]  mult;
    } row_t;
    localparam int STEP = 150;
    row_t rows [8] = '{
        '{5'h02, 5'h00, 7'h01, 12'hCE4, 1'b0, 3'h0, 3'h0},
        '{5'h1D, 5'h1D, 7'h7F, 12'h546, 1'b0, 3'h4, 3'h5},
        '{5'h00, 5'h06, 7'h40, 12'h000, 1'b1, 3'h1, 3'h0},
        '{5'h01, 5'h0B, 7'h41, 12'h000, 1'b1, 3'h1, 3'h5},
        '{5'h0A, 5'h0C, 7'h20, 12'h9C4, 1'b0, 3'h2, 3'h0},
        '{5'h1F, 5'h11, 7'h00, 12'h000, 1'b1, 3'h2, 3'h5},
        '{5'h11, 5'h1E, 7'h55, 12'h708, 1'b0, 3'h0, 3'h0},
        '{5'h17, 5'h17, 7'h10, 12'h5DC, 1'b0, 3'h3, 3'h5}
    };
    int                        n_tests = 0;
    int                        n_mismatch = 0;
    logic                      core_clk, reset, enable_pin, major_fault;
    logic [6:0]                bus_addr_strap;
    logic                      vout_adc_valid, comp_adc_valid;
    logic [4:0]                vout_adc_code, comp_adc_code;
    logic [11:0]               precharge_mv, droop_mv, vout_meas_mv;
    logic                      vout_select_strap_bias, compensator_select_strap_bias;
    logic                      config_done, vout_code_reserved, converter_run;
    logic                      prebias_start, power_good_out, power_good_oe, pg_pin;
    logic [11:0]               setpoint_mv, ref_mv;
    converter_pkg::comp_sel_t  compensator;

    strap_config_enable_power_good #(
        .MV_W           (12),
        .RAMP_STEP_MV   (STEP),
        .PREBIAS_MIN_MV (50)
    ) strap_config_enable_power_good_i (
        .core_clk                      (core_clk),
        .reset                         (reset),
        .enable_pin                    (enable_pin),
        .bus_addr_strap                (bus_addr_strap),
        .vout_adc_valid                (vout_adc_valid),
        .vout_adc_code                 (vout_adc_code),
        .comp_adc_valid                (comp_adc_valid),
        .comp_adc_code                 (comp_adc_code),
        .vout_meas_mv                  (vout_meas_mv),
        .major_fault                   (major_fault),
        .vout_select_strap_bias        (vout_select_strap_bias),
        .compensator_select_strap_bias (compensator_select_strap_bias),
        .config_done                   (config_done),
        .vout_code_reserved            (vout_code_reserved),
        .setpoint_mv                   (setpoint_mv),
        .ref_mv                        (ref_mv),
        .converter_run                 (converter_run),
        .prebias_start                 (prebias_start),
        .compensator                   (compensator),
        .power_good_out                (power_good_out),
        .power_good_oe                 (power_good_oe)
    );

    sequencer_plant_model sequencer_plant_model_i (
        .core_clk       (core_clk),
        .reset          (reset),
        .converter_run  (converter_run),
        .ref_mv         (ref_mv),
        .precharge_mv   (precharge_mv),
        .droop_mv       (droop_mv),
        .power_good_out (power_good_out),
        .power_good_oe  (power_good_oe),
        .vout_meas_mv   (vout_meas_mv),
        .pg_pin         (pg_pin)
    );

    always #5 core_clk = ~core_clk;

    // ****************************************
    // stimulus tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wait_for(input logic run_sel, input logic lvl, output int cnt);
        cnt = 0;
        while (((run_sel ? converter_run : pg_pin) !== lvl) && cnt < 4000)
        begin
            tick(1);
            cnt++;
        end
        if (cnt >= 4000)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, !lvl, lvl);
        end
    endtask

    task automatic strap_up(input logic [4:0] vc, input logic [4:0] cc, input logic [6:0] a);
        reset = 1'b1;
        enable_pin = 1'b0;
        major_fault = 1'b0;
        precharge_mv = 12'h000;
        droop_mv = 12'h000;
        bus_addr_strap = a;
        tick(12);
        `CHECK(vout_select_strap_bias, 1'b1)
        `CHECK(compensator_select_strap_bias, 1'b1)
        `CHECK({config_done, converter_run, power_good_oe}, 3'h0)
        reset = 1'b0;
        tick(105);
        vout_adc_code = vc;
        comp_adc_code = cc;
        vout_adc_valid = 1'b1;
        comp_adc_valid = 1'b1;
        tick(1);
        vout_adc_valid = 1'b0;
        comp_adc_valid = 1'b0;
        tick(3);
        `CHECK(config_done, 1'b1)
        `CHECK(vout_select_strap_bias, 1'b0)
        `CHECK(compensator_select_strap_bias, 1'b0)
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #400000;
        n_mismatch++;
        end_sim();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        int cnt;
        core_clk = 1'b0;
        reset = 1'b1;
        enable_pin = 1'b0;
        major_fault = 1'b0;
        bus_addr_strap = 7'h00;
        vout_adc_valid = 1'b0;
        comp_adc_valid = 1'b0;
        vout_adc_code = 5'h00;
        comp_adc_code = 5'h00;
        precharge_mv = 12'h000;
        droop_mv = 12'h000;
        for (int i = 0; i < 8; i++)
        begin
            strap_up(rows[i].vcode, rows[i].ccode, rows[i].addr);
            `CHECK(setpoint_mv, rows[i].sp)
            `CHECK(vout_code_reserved, rows[i].rsv)
            `CHECK(compensator.base, rows[i].base)
            `CHECK(compensator.mult, rows[i].mult)
            // host scaling of the 2.5V strap code in the 5V divider arrangement
            if (rows[i].vcode == 5'h0A)
            begin
                `CHECK({setpoint_mv, 1'b0}, 13'h1388)
            end
            enable_pin = 1'b1;
            if (rows[i].rsv)
            begin
                tick(50);
                `CHECK(converter_run, 1'b0)
            end
            else
            begin
                wait_for(1'b1, 1'b1, cnt);
                `CHECK(cnt <= 4, 1'b1)
                `CHECK(prebias_start, 1'b0)
                `CHECK(pg_pin, 1'b0)
                wait_for(1'b0, 1'b1, cnt);
                `CHECK(ref_mv, rows[i].sp)
                `CHECK(power_good_oe, rows[i].addr <= 7'h40)
                `CHECK(power_good_out, rows[i].addr <= 7'h40)
                enable_pin = 1'b0;
                wait_for(1'b1, 1'b0, cnt);
                `CHECK(cnt >= (rows[i].sp / STEP - 1) * 100, 1'b1)
                `CHECK(ref_mv, 12'h000)
                `CHECK(pg_pin, 1'b0)
            end
            $display("row %0d done", i);
        end
        strap_up(5'h1D, 5'h00, 7'h7F);
        precharge_mv = 12'h384;
        tick(2);
        enable_pin = 1'b1;
        wait_for(1'b1, 1'b1, cnt);
        tick(1);
        `CHECK(prebias_start, 1'b1)
        `CHECK(ref_mv >= 12'h384 && ref_mv <= 12'h41A, 1'b1)
        wait_for(1'b0, 1'b1, cnt);
        bus_addr_strap = 7'h01;
        tick(5);
        `CHECK(power_good_oe, 1'b0)
        $display("pre-bias start done");
        major_fault = 1'b1;
        tick(3);
        `CHECK(pg_pin, 1'b0)
        `CHECK(converter_run, 1'b0)
        major_fault = 1'b0;
        wait_for(1'b0, 1'b1, cnt);
        `CHECK(pg_pin, 1'b1)
        $display("fault recovery done");
        droop_mv = 12'h088;
        tick(4);
        `CHECK(pg_pin, 1'b0)
        droop_mv = 12'h087;
        tick(4);
        `CHECK(pg_pin, 1'b1)
        $display("threshold done");
        end_sim();
    end
endmodule
